// ### cma_consts.vh
// cma_consts.vh: constants for the core memory addressing block
// assumes: included by the design files of this block only
`ifndef CMA_CONSTS_VH
`define CMA_CONSTS_VH
`define CMA_ADDR_STACK_POINTER 8'h81
`define CMA_ADDR_PROG_STORE_CTL 8'h8f
`define CMA_ADDR_STATUS_WORD 8'hd0
`define CMA_RST_STACK_POINTER 8'h07
`define CMA_RST_PROG_STORE_CTL 8'h00
`define CMA_RST_STATUS_WORD 8'h00
`define CMA_BIT_WRITE_ENABLE 0
`define CMA_BIT_BANK_LOW 3
`define CMA_BIT_BANK_HIGH 4
`define CMA_SFR_SPACE_BASE 8'h80
`define CMA_BIT_RAM_BASE 8'h20
`define CMA_CODE_RESERVED_ABOVE 16'hfbff
`define CMA_OPC_NOP 8'h00
`define CMA_OPC_UNUSED 8'ha5
`define CMA_OP_BYTE 2'h0
`define CMA_OP_BIT 2'h1
`define CMA_OP_INDIRECT 2'h2
`define CMA_OP_REG 2'h3
`define CMA_BR_NONE 3'h0
`define CMA_BR_REL 3'h1
`define CMA_BR_ABS 3'h2
`define CMA_BR_LONG 3'h3
`define CMA_BR_IMM16 3'h4
`endif

// ### cma_ram.v
// cma_ram.v: 256 x 8 internal data ram, one port, registered read data
// assumes: single clock, write and read addresses driven by the owner
`timescale 1ns/1ps
module cma_ram #(
	parameter AW = 8,
	parameter DW = 8
) (
	input wire clk_sys,
	input wire we,
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wdata,
	output reg [DW-1:0] rdata
);
reg [DW-1:0] mem [0:(1<<AW)-1];
always @(posedge clk_sys) begin
	if (we) begin
		mem[addr] <= wdata;
	end
	rdata <= mem[addr];
end
endmodule // cma_ram

// ### cma_core_mem.v
// cma_core_mem.v: operand address decode, stack, banks and program
// counter targets of the 8-bit controller core
// assumes: execution unit issues one access per cycle and waits two
// cycles for read data, three for indirect; peripheral registers answer on the sfr port
`timescale 1ns/1ps
`include "cma_consts.vh"
module cma_core_mem #(
	parameter CODE_64K = 1
) (
	input wire clk_sys,
	input wire rst_n,
	// operand access from the execution unit
	input wire acc_req,
	input wire acc_wr,
	input wire [1:0] acc_type,
	input wire [7:0] acc_addr,
	input wire [7:0] acc_wdata,
	input wire acc_bit_val,
	input wire stk_push,
	input wire stk_pop,
	output reg [7:0] acc_rdata_q,
	output reg acc_bit_q,
	output reg acc_valid_q,
	output reg acc_bad_bit_q,
	// peripheral register side
	output wire sfr_rd,
	output wire sfr_wr,
	output wire [7:0] sfr_addr,
	output wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	// program counter targets and opcodes
	input wire [7:0] opcode,
	input wire [2:0] br_kind,
	input wire [15:0] pc_next,
	input wire [7:0] opnd_lo,
	input wire [7:0] opnd_hi,
	input wire [2:0] page_hi,
	output wire [7:0] opcode_eff,
	output wire [15:0] br_target,
	// external move writes
	input wire xmov_wr,
	input wire [15:0] xmov_addr,
	output wire code_wr,
	output wire xdata_wr,
	output wire code_reserved,
	// register views
	output wire [7:0] stack_pointer,
	output wire [1:0] bank_sel
);

////////////////////////////////////////////////////////////////////////
// functions

// bit address to byte address; the bit position comes from bitpos
function [7:0] bit_byte;
	input [7:0] ba;
	begin
		if (ba[7]) begin
			bit_byte = {ba[7:3], 3'h0};
		end else begin
			bit_byte = `CMA_BIT_RAM_BASE + {4'h0, ba[6:3]};
		end
	end
endfunction

function bit_capable;
	input [7:0] a;
	begin
		bit_capable = (a[2:0] == 3'h0);
	end
endfunction

////////////////////////////////////////////////////////////////////////
// registers held here

reg [7:0] stk_ptr_q;
reg [7:0] store_ctl_q;
reg [7:0] status_word_q;

assign stack_pointer = stk_ptr_q;
assign bank_sel = {status_word_q[`CMA_BIT_BANK_HIGH],
	status_word_q[`CMA_BIT_BANK_LOW]};

////////////////////////////////////////////////////////////////////////
// address decode

reg [7:0] byte_addr;
reg is_sfr;
reg [7:0] ram_addr;
reg ram_we;
reg [7:0] ram_wdata;
wire [7:0] ram_rdata;
wire [2:0] bitpos = acc_addr[2:0];
wire [4:0] ptr_loc = {bank_sel, 2'h0, acc_addr[0]};
wire is_bit = (acc_type == `CMA_OP_BIT);

// stack: push writes pointer+1, pop reads pointer
wire [7:0] stk_ptr_inc = stk_ptr_q + 8'h01;

// pending operation after a pointer fetch or a read-modify-write
reg [2:0] st_q;
reg [2:0] st_d;
localparam ST_IDLE = 3'b001;
localparam ST_PTR = 3'b010;
localparam ST_RMW = 3'b100;
reg [7:0] hold_addr_q;
reg hold_wr_q;
reg [7:0] hold_wdata_q;
reg hold_bitval_q;
reg [2:0] hold_pos_q;
reg hold_sfr_q;

always @* begin
	byte_addr = acc_addr;
	is_sfr = 1'b0;
	ram_addr = 8'h00;
	ram_we = 1'b0;
	ram_wdata = acc_wdata;
	st_d = ST_IDLE;
	case (st_q)
	ST_IDLE: begin
		if (stk_push) begin
			ram_addr = stk_ptr_inc;
			ram_we = 1'b1;
		end else if (stk_pop) begin
			ram_addr = stk_ptr_q;
		end else if (acc_req) begin
			case (acc_type)
			`CMA_OP_REG: begin
				ram_addr = {3'h0, bank_sel, acc_addr[2:0]};
				ram_we = acc_wr;
			end
			`CMA_OP_INDIRECT: begin
				ram_addr = {3'h0, ptr_loc};
				st_d = ST_PTR;
			end
			`CMA_OP_BIT: begin
				byte_addr = bit_byte(acc_addr);
				is_sfr = acc_addr[7];
				ram_addr = byte_addr;
				if (acc_wr) begin
					st_d = ST_RMW;
				end
			end
			default: begin
				is_sfr = (acc_addr >= `CMA_SFR_SPACE_BASE);
				ram_addr = acc_addr;
				ram_we = acc_wr & ~is_sfr;
			end
			endcase
		end
	end
	ST_PTR: begin
		// pointer byte now read; full 8-bit space reaches upper ram
		ram_addr = ram_rdata;
		ram_we = hold_wr_q;
		ram_wdata = hold_wdata_q;
	end
	ST_RMW: begin
		ram_addr = hold_addr_q;
		ram_we = ~hold_sfr_q;
		ram_wdata = ram_rdata;
		ram_wdata[hold_pos_q] = hold_bitval_q;
	end
	default: begin
		st_d = ST_IDLE;
	end
	endcase
end

cma_ram #(
	.AW(8),
	.DW(8)
) u_ram (
	.clk_sys(clk_sys),
	.we(ram_we),
	.addr(ram_addr),
	.wdata(ram_wdata),
	.rdata(ram_rdata)
);

////////////////////////////////////////////////////////////////////////
// peripheral register port; own registers answer locally

wire own_sfr = (byte_addr == `CMA_ADDR_STACK_POINTER) |
	(byte_addr == `CMA_ADDR_PROG_STORE_CTL) |
	(byte_addr == `CMA_ADDR_STATUS_WORD);
reg [7:0] sfr_cap_q;
// only the status word sits on a bit row among the own registers
wire hold_own = (hold_addr_q == `CMA_ADDR_STATUS_WORD);
wire sfr_bitwr = (st_q == ST_RMW) & hold_sfr_q & ~hold_own;
wire [7:0] bit_merged = (sfr_cap_q & ~(8'h01 << hold_pos_q)) |
	({7'h00, hold_bitval_q} << hold_pos_q);
wire direct_sfr = (st_q == ST_IDLE) & acc_req & ~stk_push & ~stk_pop &
	is_sfr;
// unoccupied sfr addresses pass through; their answer is undefined
assign sfr_rd = direct_sfr & ~own_sfr & (~acc_wr | is_bit);
assign sfr_wr = (direct_sfr & ~own_sfr & acc_wr & ~is_bit) | sfr_bitwr;
assign sfr_addr = sfr_bitwr ? hold_addr_q : byte_addr;
assign sfr_wdata = sfr_bitwr ? bit_merged : acc_wdata;

reg [7:0] own_rdata;
always @* begin
	case (byte_addr)
	`CMA_ADDR_STACK_POINTER: own_rdata = stk_ptr_q;
	`CMA_ADDR_PROG_STORE_CTL: own_rdata = store_ctl_q;
	`CMA_ADDR_STATUS_WORD: own_rdata = status_word_q;
	default: own_rdata = 8'h00;
	endcase
end

////////////////////////////////////////////////////////////////////////
// sequential state

reg rd_pend_q;
reg rd_sfr_q;
reg [2:0] rd_pos_q;
wire wr_own = direct_sfr & own_sfr & acc_wr & ~is_bit;
wire bitwr_own = (st_q == ST_RMW) & hold_sfr_q & hold_own;

always @(posedge clk_sys) begin
	if (!rst_n) begin
		stk_ptr_q <= `CMA_RST_STACK_POINTER;
		store_ctl_q <= `CMA_RST_PROG_STORE_CTL;
		status_word_q <= `CMA_RST_STATUS_WORD;
		st_q <= ST_IDLE;
		hold_addr_q <= 8'h00;
		hold_wr_q <= 1'b0;
		hold_wdata_q <= 8'h00;
		hold_bitval_q <= 1'b0;
		hold_pos_q <= 3'h0;
		hold_sfr_q <= 1'b0;
		rd_pend_q <= 1'b0;
		rd_sfr_q <= 1'b0;
		sfr_cap_q <= 8'h00;
		rd_pos_q <= 3'h0;
		acc_rdata_q <= 8'h00;
		acc_bit_q <= 1'b0;
		acc_valid_q <= 1'b0;
		acc_bad_bit_q <= 1'b0;
	end else begin
		st_q <= st_d;
		acc_bad_bit_q <= 1'b0;
		if (stk_push) begin
			stk_ptr_q <= stk_ptr_inc;
		end else if (stk_pop) begin
			stk_ptr_q <= stk_ptr_q - 8'h01;
		end else if (bitwr_own || wr_own) begin
			case (bitwr_own ? hold_addr_q : byte_addr)
			`CMA_ADDR_STACK_POINTER: stk_ptr_q <= acc_wdata;
			`CMA_ADDR_PROG_STORE_CTL: store_ctl_q <= acc_wdata;
			`CMA_ADDR_STATUS_WORD: begin
				status_word_q <= bitwr_own ? bit_merged : acc_wdata;
			end
			default: begin
				stk_ptr_q <= stk_ptr_q;
			end
			endcase
		end
		if (st_q == ST_IDLE && acc_req && !stk_push && !stk_pop) begin
			hold_addr_q <= byte_addr;
			hold_wr_q <= acc_wr;
			hold_wdata_q <= acc_wdata;
			hold_bitval_q <= acc_bit_val;
			hold_pos_q <= bitpos;
			hold_sfr_q <= is_sfr;
			if (is_bit && is_sfr && !bit_capable(byte_addr)) begin
				acc_bad_bit_q <= 1'b1;
			end
		end
		if (direct_sfr) begin
			sfr_cap_q <= own_sfr ? own_rdata : sfr_rdata;
		end
		// a read answers the cycle after ram data is registered
		rd_pend_q <= (st_q == ST_IDLE) & ((acc_req & ~acc_wr &
			(acc_type != `CMA_OP_INDIRECT)) | stk_pop) |
			((st_q == ST_PTR) & ~hold_wr_q);
		rd_sfr_q <= direct_sfr;
		rd_pos_q <= (st_q == ST_IDLE) ? bitpos : hold_pos_q;
		acc_valid_q <= rd_pend_q;
		if (rd_pend_q) begin
			acc_rdata_q <= rd_sfr_q ? sfr_cap_q : ram_rdata;
			acc_bit_q <= rd_sfr_q ? sfr_cap_q[rd_pos_q] :
				ram_rdata[rd_pos_q];
		end
	end
end

////////////////////////////////////////////////////////////////////////
// opcode and branch targets

assign opcode_eff = (opcode == `CMA_OPC_UNUSED) ? `CMA_OPC_NOP : opcode;

reg [15:0] tgt;
always @* begin
	case (br_kind)
	`CMA_BR_REL: tgt = pc_next + {{8{opnd_lo[7]}}, opnd_lo};
	`CMA_BR_ABS: tgt = {pc_next[15:11], page_hi, opnd_lo};
	`CMA_BR_LONG: tgt = {opnd_hi, opnd_lo};
	`CMA_BR_IMM16: tgt = {opnd_hi, opnd_lo};
	default: tgt = pc_next;
	endcase
end
assign br_target = tgt;

////////////////////////////////////////////////////////////////////////
// external move write steering

wire wen = store_ctl_q[`CMA_BIT_WRITE_ENABLE];
assign code_wr = xmov_wr & wen;
assign xdata_wr = xmov_wr & ~wen;
// reserved top of code space is only flagged; flash control rejects it
assign code_reserved = (CODE_64K != 0) &&
	(xmov_addr > `CMA_CODE_RESERVED_ABOVE);

endmodule // cma_core_mem

// ### cma_sfr_model.sv
// cma_sfr_model.sv: peripheral registers behind the sfr port
// assumes: read data is wanted in the cycle of sfr_rd
`timescale 1ns/1ps
module cma_sfr_model (
	input wire clk_sys,
	input wire sfr_rd,
	input wire sfr_wr,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata
);
	logic [7:0] mem [0:127];
	logic [7:0] last_q = 8'h00;
	////////////////////////////////////////
	// idle bus shows the inverse so stale data never passes for fresh
	assign sfr_rdata = sfr_rd ? mem[sfr_addr[6:0]] : ~last_q;
	always @(posedge clk_sys) begin
		if (sfr_wr)
			mem[sfr_addr[6:0]] <= sfr_wdata;
		if (sfr_rd)
			last_q <= mem[sfr_addr[6:0]];
	end
	initial for (int i = 0; i < 128; i++) mem[i] = 8'h00;
endmodule // cma_sfr_model

// ### cma_core_mem_chk.sv
// cma_core_mem_chk.sv: port assertions for cma_core_mem
// assumes: bound to the top module, requests spaced as the contract says
`timescale 1ns/1ps
module cma_core_mem_chk (
	input wire clk_sys,
	input wire rst_n,
	input wire acc_req,
	input wire acc_wr,
	input wire [1:0] acc_type,
	input wire [7:0] acc_addr,
	input wire stk_push,
	input wire stk_pop,
	input wire acc_valid_q,
	input wire acc_bad_bit_q,
	input wire sfr_rd,
	input wire [7:0] sfr_addr,
	input wire [7:0] opcode,
	input wire [7:0] opcode_eff,
	input wire [2:0] br_kind,
	input wire [15:0] pc_next,
	input wire [7:0] opnd_lo,
	input wire [7:0] opnd_hi,
	input wire [2:0] page_hi,
	input wire [15:0] br_target,
	input wire [7:0] stack_pointer
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// own registers never reach the peripheral port
	wire own = acc_addr == 8'h81 || acc_addr == 8'h8f || acc_addr == 8'hd0;
	wire rd_go = acc_req && !acc_wr && !stk_push && !stk_pop;
	wire bit_go = acc_req && acc_type == 2'h1 && acc_addr[7] && !stk_push && !stk_pop;
	////////////////////////////////////////
	sfr_direct_a: assert property (rd_go && acc_type == 2'h0 && acc_addr[7]
		&& !own |-> sfr_rd && sfr_addr == acc_addr) else $error("sfr read missing");
	ram_direct_a: assert property (rd_go && acc_type != 2'h1 && acc_type != 2'h3
		&& !(acc_type == 2'h0 && acc_addr[7]) |-> !sfr_rd) else $error("ram read hit sfr");
	direct_lat_a: assert property (rd_go && acc_type != 2'h2 |-> ##2 acc_valid_q)
		else $error("direct read late");
	ind_lat_a: assert property (rd_go && acc_type == 2'h2 |-> !acc_valid_q [*3] ##1 acc_valid_q)
		else $error("indirect read timing");
	unused_op_a: assert property (opcode_eff == (opcode == 8'ha5 ? 8'h00 : opcode))
		else $error("opcode mapping wrong");
	rel_target_a: assert property (br_kind == 3'h1 |-> br_target == pc_next + {{8{opnd_lo[7]}}, opnd_lo})
		else $error("relative target wrong");
	page_target_a: assert property (br_kind == 3'h2 |-> br_target == {pc_next[15:11], page_hi, opnd_lo})
		else $error("page target wrong");
	long_target_a: assert property (br_kind == 3'h3 || br_kind == 3'h4 |-> br_target == {opnd_hi, opnd_lo})
		else $error("long target wrong");
	reset_ptr_a: assert property (disable iff (1'b0) !rst_n |=> stack_pointer == 8'h07)
		else $error("pointer reset wrong");
	push_step_a: assert property (stk_push && !stk_pop |=> stack_pointer == $past(stack_pointer) + 8'h01)
		else $error("push step wrong");
	pop_step_a: assert property (stk_pop && !stk_push |=> stack_pointer == $past(stack_pointer) - 8'h01)
		else $error("pop step wrong");
	sfr_bit_a: assert property (bit_go && acc_addr[7:3] != 5'h1a
		|-> sfr_rd && sfr_addr == {acc_addr[7:3], 3'h0} ##1 !acc_bad_bit_q)
		else $error("sfr bit row wrong");
	cover property (stk_push);
	cover property (rd_go && acc_type == 2'h2);
	cover property (acc_req && acc_type == 2'h1 && acc_wr);
endmodule // cma_core_mem_chk

// ### cma_core_mem_tb.sv
// cma_core_mem_tb.sv: directed bench for cma_core_mem
// assumes: cma_sfr_model answers the sfr port
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module cma_core_mem_tb;
	logic clk_sys = 1'h0, rst_n = 1'h0, acc_req = 1'h0, acc_wr = 1'h0;
	logic acc_bit_val = 1'h0, stk_push = 1'h0, stk_pop = 1'h0, xmov_wr = 1'h0;
	logic [1:0] acc_type = 2'h0;
	logic [7:0] acc_addr = 8'h00, acc_wdata = 8'h00, opcode = 8'h00, rd;
	logic [7:0] opnd_lo = 8'h00, opnd_hi = 8'h00;
	logic [2:0] br_kind = 3'h0, page_hi = 3'h0;
	logic [15:0] pc_next = 16'h0000, xmov_addr = 16'h0000;
	wire [7:0] acc_rdata_q, sfr_addr, sfr_wdata, sfr_rdata, opcode_eff, stack_pointer;
	wire acc_bit_q, acc_valid_q, acc_bad_bit_q, sfr_rd, sfr_wr;
	wire code_wr, xdata_wr, code_reserved;
	wire [15:0] br_target;
	wire [1:0] bank_sel;
	int err_total = 0, checks_done = 0, i;
	always #5 clk_sys = ~clk_sys;
	cma_core_mem i_cma_core_mem (.clk_sys(clk_sys), .rst_n(rst_n), .acc_req(acc_req),
		.acc_wr(acc_wr), .acc_type(acc_type), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
		.acc_bit_val(acc_bit_val), .stk_push(stk_push), .stk_pop(stk_pop),
		.acc_rdata_q(acc_rdata_q), .acc_bit_q(acc_bit_q), .acc_valid_q(acc_valid_q),
		.acc_bad_bit_q(acc_bad_bit_q), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.opcode(opcode), .br_kind(br_kind), .pc_next(pc_next), .opnd_lo(opnd_lo),
		.opnd_hi(opnd_hi), .page_hi(page_hi), .opcode_eff(opcode_eff),
		.br_target(br_target), .xmov_wr(xmov_wr), .xmov_addr(xmov_addr),
		.code_wr(code_wr), .xdata_wr(xdata_wr), .code_reserved(code_reserved),
		.stack_pointer(stack_pointer), .bank_sel(bank_sel));
	cma_sfr_model i_cma_sfr_model (.clk_sys(clk_sys), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
	task results;
		if (err_total == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task wait_valid;
		int n;
		n = 0;
		while (acc_valid_q !== 1'h1) begin
			@(negedge clk_sys);
			n++;
			if (n > 5) begin
				err_total++;
				results();
			end
		end
		rd = acc_rdata_q;
	endtask
	// writes leave an idle cycle so indirect and bit writes can finish
	task acc(input [1:0] t, input w, input [7:0] a, input [7:0] d, input bv);
		@(negedge clk_sys);
		acc_req = 1'h1;
		acc_wr = w;
		acc_type = t;
		acc_addr = a;
		acc_wdata = d;
		acc_bit_val = bv;
		@(negedge clk_sys);
		acc_req = 1'h0;
		if (w)
			@(negedge clk_sys);
		else
			wait_valid();
	endtask
	task wr(input [7:0] a, input [7:0] d);
		acc(2'h0, 1'h1, a, d, 1'h0);
	endtask
	task rdd(input [7:0] a);
		acc(2'h0, 1'h0, a, 8'h00, 1'h0);
	endtask
	task push(input [7:0] d);
		@(negedge clk_sys);
		stk_push = 1'h1;
		acc_wdata = d;
		@(negedge clk_sys);
		stk_push = 1'h0;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (4) @(negedge clk_sys);
		rst_n = 1'h1;
		`CHK(stack_pointer, 8'h07)
		rdd(8'hd0);
		`CHK(rd, 8'h00)
		rdd(8'h8f);
		`CHK(rd, 8'h00)
		push(8'h5a);
		`CHK(stack_pointer, 8'h08)
		rdd(8'h08);
		`CHK(rd, 8'h5a)
		@(negedge clk_sys);
		stk_pop = 1'h1;
		@(negedge clk_sys);
		stk_pop = 1'h0;
		wait_valid();
		`CHK(rd, 8'h5a)
		`CHK(stack_pointer, 8'h07)
		for (i = 0; i < 4; i++) begin
			wr(8'hd0, 8'(i << 3));
			`CHK(bank_sel, 2'(i))
			acc(2'h3, 1'h1, 8'h03, 8'(8'h30 + i), 1'h0);
			rdd(8'(i * 8 + 3));
			`CHK(rd, 8'(8'h30 + i))
		end
		wr(8'hd0, 8'h00);
		wr(8'h00, 8'h90);
		acc(2'h2, 1'h1, 8'h00, 8'hc3, 1'h0);
		wr(8'h90, 8'h11);
		acc(2'h2, 1'h0, 8'h00, 8'h00, 1'h0);
		`CHK(rd, 8'hc3)
		// only occupied peripheral addresses are used
		rdd(8'h90);
		`CHK(rd, 8'h11)
		wr(8'h01, 8'h40);
		wr(8'h40, 8'h77);
		acc(2'h2, 1'h0, 8'h01, 8'h00, 1'h0);
		`CHK(rd, 8'h77)
		wr(8'h22, 8'h08);
		acc(2'h1, 1'h0, 8'h13, 8'h00, 1'h0);
		`CHK(acc_bit_q, 1'h1)
		acc(2'h1, 1'h0, 8'h12, 8'h00, 1'h0);
		`CHK(acc_bit_q, 1'h0)
		acc(2'h1, 1'h1, 8'h10, 8'h00, 1'h1);
		rdd(8'h22);
		`CHK(rd, 8'h09)
		acc(2'h1, 1'h0, 8'h94, 8'h00, 1'h0);
		`CHK(acc_bit_q, 1'h1)
		acc(2'h1, 1'h1, 8'h91, 8'h00, 1'h1);
		rdd(8'h90);
		`CHK(rd, 8'h13)
		wr(8'h81, 8'ha0);
		push(8'h3c);
		`CHK(stack_pointer, 8'ha1)
		wr(8'h00, 8'ha1);
		acc(2'h2, 1'h0, 8'h00, 8'h00, 1'h0);
		`CHK(rd, 8'h3c)
		opcode = 8'ha5;
		pc_next = 16'h1000;
		opnd_lo = 8'hfe;
		br_kind = 3'h1;
		#1;
		`CHK(opcode_eff, 8'h00)
		`CHK(br_target, 16'h0ffe)
		pc_next = 16'h1234;
		page_hi = 3'h5;
		opnd_lo = 8'h67;
		br_kind = 3'h2;
		#1;
		`CHK(br_target, 16'h1567)
		opnd_hi = 8'hab;
		opnd_lo = 8'hcd;
		br_kind = 3'h3;
		#1;
		`CHK(br_target, 16'habcd)
		br_kind = 3'h4;
		#1;
		`CHK(br_target, 16'habcd)
		xmov_wr = 1'h1;
		xmov_addr = 16'hfc00;
		#1;
		`CHK(xdata_wr, 1'h1)
		`CHK(code_reserved, 1'h1)
		wr(8'h8f, 8'h01);
		`CHK(code_wr, 1'h1)
		`CHK(xdata_wr, 1'h0)
		xmov_addr = 16'hfbff;
		#1;
		`CHK(code_reserved, 1'h0)
		results();
	end
endmodule // cma_core_mem_tb
bind cma_core_mem cma_core_mem_chk i_cma_core_mem_chk (.clk_sys(clk_sys),
	.rst_n(rst_n), .acc_req(acc_req), .acc_wr(acc_wr), .acc_type(acc_type),
	.acc_addr(acc_addr), .stk_push(stk_push), .stk_pop(stk_pop),
	.acc_valid_q(acc_valid_q), .acc_bad_bit_q(acc_bad_bit_q), .sfr_rd(sfr_rd),
	.sfr_addr(sfr_addr), .opcode(opcode), .opcode_eff(opcode_eff),
	.br_kind(br_kind), .pc_next(pc_next), .opnd_lo(opnd_lo), .opnd_hi(opnd_hi),
	.page_hi(page_hi), .br_target(br_target), .stack_pointer(stack_pointer));
